// File: verilog/rcf_defs.svh
/*
 Constants of the reset-cause flag block: register offsets, bit positions,
 reset values and encodings. Assumes inclusion by bare name from design files.
*/
`ifndef RCF_DEFS_SVH
`define RCF_DEFS_SVH

// Register byte offsets
`define RCF_ADDR_FLAGS 8'h00
`define RCF_ADDR_STATUS 8'h04
`define RCF_ADDR_MASK 8'h08

// Flag bit positions (status and mask share the layout)
`define RCF_BIT_OVF 7
`define RCF_BIT_UNF 6
`define RCF_BIT_RSVD 5
`define RCF_BIT_WDT 4
`define RCF_BIT_PIN 3
`define RCF_BIT_INSTR 2
`define RCF_BIT_POR 1
`define RCF_BIT_BOR 0

// Reset values and masks
`define RCF_FLAGS_RST 8'h1c
`define RCF_IMPL_MASK 8'hdf
`define RCF_SYNC_RST 5'h01

// Synchroniser lanes
`define RCF_SYN_PIN 0
`define RCF_SYN_POR 1
`define RCF_SYN_BOR 2
`define RCF_SYN_LOW_POWER_SUPPLY_MONITOR 3
`define RCF_SYN_STKEN 4

`endif

// File: verilog/rcf_pkg.sv
/*
 Types of the reset-cause flag block.
 Assumes rcf_defs.svh holds all numeric constants.
*/
package rcf_pkg;
   typedef logic [7:0] rcf_addr_t;
   typedef logic [31:0] rcf_data_t;
   typedef logic [7:0] rcf_flags_t;
   typedef enum logic [1:0] {
      RCF_RESP_OKAY = 2'b00,
      RCF_RESP_SLVERR = 2'b10
   } rcf_resp_e;
endpackage : rcf_pkg

// File: verilog/rcf_regbus_if.sv
/*
 Internal register access between the bus slave and the register file.
 Assumes one clock; all signals are same-cycle combinational handshakes.
*/
`timescale 1ns/1ps
interface rcf_regbus_if;
   import rcf_pkg::*;
   logic wr_en;
   rcf_addr_t wr_addr;
   rcf_data_t wr_data;
   logic [3:0] wr_strb;
   logic wr_hit;
   rcf_addr_t rd_addr;
   rcf_data_t rd_data;
   logic rd_hit;
   modport bus_side (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_hit, rd_data, rd_hit);
   modport reg_side (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_hit, rd_data, rd_hit);
endinterface : rcf_regbus_if

// File: verilog/rcf_axil_slave.sv
/*
 AXI4-Lite slave: takes one write and one read at a time and hands them to
 the register file over rcf_regbus_if. Assumes the register file answers
 hit flags and read data combinationally from the offered address.
*/
`timescale 1ns/1ps
module rcf_axil_slave
   import rcf_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire rcf_addr_t awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire rcf_data_t wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output rcf_resp_e bresp,
   output logic bvalid,
   input wire logic bready,
   input wire rcf_addr_t araddr,
   input wire logic arvalid,
   output logic arready,
   output rcf_data_t rdata,
   output rcf_resp_e rresp,
   output logic rvalid,
   input wire logic rready,
   rcf_regbus_if.bus_side rif
);
   logic aw_full_reg, w_full_reg, ar_full_reg;
   rcf_addr_t awaddr_reg, araddr_reg;
   rcf_data_t wdata_reg;
   logic [3:0] wstrb_reg;

   // Write goes ahead once address and data are both held
   assign rif.wr_en = aw_full_reg & w_full_reg & ~bvalid;
   assign rif.wr_addr = awaddr_reg;
   assign rif.wr_data = wdata_reg;
   assign rif.wr_strb = wstrb_reg;
   assign rif.rd_addr = araddr_reg;

   // Write address channel
   always_ff @(posedge clk) begin
      if (!rstn) begin
         awready <= 1'b1;
         aw_full_reg <= 1'b0;
         awaddr_reg <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_full_reg <= 1'b1;
         awaddr_reg <= awaddr;
      end else begin
         if (rif.wr_en) aw_full_reg <= 1'b0;
         if (bvalid && bready) awready <= 1'b1;
      end
   end

   // Write data channel
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wready <= 1'b1;
         w_full_reg <= 1'b0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_full_reg <= 1'b1;
         wdata_reg <= wdata;
         wstrb_reg <= wstrb;
      end else begin
         if (rif.wr_en) w_full_reg <= 1'b0;
         if (bvalid && bready) wready <= 1'b1;
      end
   end

   // Write response, error for unmapped offsets
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bvalid <= 1'b0;
         bresp <= RCF_RESP_OKAY;
      end else if (rif.wr_en) begin
         bvalid <= 1'b1;
         bresp <= rif.wr_hit ? RCF_RESP_OKAY : RCF_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read address and data
   always_ff @(posedge clk) begin
      if (!rstn) begin
         arready <= 1'b1;
         ar_full_reg <= 1'b0;
         araddr_reg <= '0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RCF_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         ar_full_reg <= 1'b1;
         araddr_reg <= araddr;
      end else if (ar_full_reg) begin
         ar_full_reg <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rif.rd_data;
         rresp <= rif.rd_hit ? RCF_RESP_OKAY : RCF_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end
endmodule : rcf_axil_slave

// File: verilog/rcf_reset_cause_flags.sv
/*
 Reset-cause flag register with event status, interrupt mask and AXI4-Lite
 access. Assumes stack, watchdog and instruction pulses come from logic on
 clk; pin, supply monitor and stack-reset-enable levels are asynchronous.
*/
`timescale 1ns/1ps
`include "rcf_defs.svh"
module rcf_reset_cause_flags
   import rcf_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire rcf_addr_t awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire rcf_data_t wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output rcf_resp_e bresp,
   output logic bvalid,
   input wire logic bready,
   input wire rcf_addr_t araddr,
   input wire logic arvalid,
   output logic arready,
   output rcf_data_t rdata,
   output rcf_resp_e rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic stack_overflow_pulse,
   input wire logic stack_underflow_pulse,
   input wire logic wdt_timeout_pulse,
   input wire logic soft_reset_instr_pulse,
   input wire logic external_reset_pin_n,
   input wire logic por_req,
   input wire logic bor_req,
   input wire logic low_power_supply_monitor,
   input wire logic stack_reset_enable,
   output rcf_flags_t reset_cause_register,
   output logic core_reset_pulse,
   output logic irq
);
   rcf_regbus_if rif();

   rcf_flags_t flags_reg, flags_next;
   rcf_flags_t status_reg, status_next;
   rcf_flags_t mask_reg;
   rcf_flags_t evt_vec;
   logic [4:0] sync1_reg, sync2_reg, prev_reg;
   logic stack_en, pin_evt, por_evt, bor_evt, bor_prev, bor_now;
   logic ovf_evt, unf_evt, wdt_evt, instr_evt;
   logic flags_wr, status_wr, mask_wr;

   // Bus slave
   rcf_axil_slave u_slave (
      .clk(clk),
      .rstn(rstn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .rif(rif.bus_side)
   );

   // Two-flop synchronisers for pin, supply monitors and the enable strap
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sync1_reg <= `RCF_SYNC_RST;
         sync2_reg <= `RCF_SYNC_RST;
         prev_reg <= `RCF_SYNC_RST;
      end else begin
         sync1_reg <= {stack_reset_enable, low_power_supply_monitor, bor_req, por_req, external_reset_pin_n};
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // Event detection from synchronised levels and same-clock pulses
   assign stack_en = sync2_reg[`RCF_SYN_STKEN];
   assign bor_now = sync2_reg[`RCF_SYN_BOR] | sync2_reg[`RCF_SYN_LOW_POWER_SUPPLY_MONITOR];
   assign bor_prev = prev_reg[`RCF_SYN_BOR] | prev_reg[`RCF_SYN_LOW_POWER_SUPPLY_MONITOR];
   assign bor_evt = bor_now & ~bor_prev;
   assign por_evt = sync2_reg[`RCF_SYN_POR] & ~prev_reg[`RCF_SYN_POR];
   assign pin_evt = prev_reg[`RCF_SYN_PIN] & ~sync2_reg[`RCF_SYN_PIN];
   assign ovf_evt = stack_overflow_pulse & stack_en;
   assign unf_evt = stack_underflow_pulse & stack_en;
   assign wdt_evt = wdt_timeout_pulse;
   assign instr_evt = soft_reset_instr_pulse;
   assign evt_vec = {ovf_evt, unf_evt, 1'b0, wdt_evt, pin_evt, instr_evt, por_evt, bor_evt};

   // Address decode; only byte lane 0 carries register data
   assign flags_wr = rif.wr_en && rif.wr_addr == `RCF_ADDR_FLAGS && rif.wr_strb[0];
   assign status_wr = rif.wr_en && rif.wr_addr == `RCF_ADDR_STATUS && rif.wr_strb[0];
   assign mask_wr = rif.wr_en && rif.wr_addr == `RCF_ADDR_MASK && rif.wr_strb[0];
   assign rif.wr_hit = rif.wr_addr == `RCF_ADDR_FLAGS || rif.wr_addr == `RCF_ADDR_STATUS ||
                       rif.wr_addr == `RCF_ADDR_MASK;

   // Read mux, upper bits read as zero
   always_comb begin
      rif.rd_hit = 1'b1;
      rif.rd_data = '0;
      unique case (rif.rd_addr)
         `RCF_ADDR_FLAGS: rif.rd_data = {24'h000000, flags_reg};
         `RCF_ADDR_STATUS: rif.rd_data = {24'h000000, status_reg};
         `RCF_ADDR_MASK: rif.rd_data = {24'h000000, mask_reg};
         default: rif.rd_hit = 1'b0;
      endcase
   end

   // Flag next value: firmware write first, hardware events override it
   always_comb begin
      flags_next = flags_reg;
      if (flags_wr) begin
         flags_next = rif.wr_data[7:0];
      end
      if (ovf_evt) begin
         flags_next[`RCF_BIT_OVF] = 1'b1;
      end
      if (unf_evt) begin
         flags_next[`RCF_BIT_UNF] = 1'b1;
      end
      if (wdt_evt) begin
         flags_next[`RCF_BIT_WDT] = 1'b0;
      end
      if (pin_evt) begin
         flags_next[`RCF_BIT_PIN] = 1'b0;
      end
      if (instr_evt) begin
         flags_next[`RCF_BIT_INSTR] = 1'b0;
      end
      if (bor_evt || por_evt) begin
         flags_next[`RCF_BIT_OVF] = 1'b0;
         flags_next[`RCF_BIT_UNF] = 1'b0;
         flags_next[`RCF_BIT_WDT] = 1'b1;
         flags_next[`RCF_BIT_PIN] = 1'b1;
         flags_next[`RCF_BIT_INSTR] = 1'b1;
      end
      if (bor_evt) begin
         flags_next[`RCF_BIT_BOR] = 1'b0;
      end
      if (por_evt) begin
         flags_next[`RCF_BIT_POR] = 1'b0;
      end
      flags_next[`RCF_BIT_RSVD] = 1'b0;
   end

   // Flag register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         flags_reg <= `RCF_FLAGS_RST;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Sticky event status, write one to clear, a new event wins
   always_comb begin
      status_next = status_reg;
      if (status_wr) begin
         status_next = status_reg & ~rif.wr_data[7:0];
      end
      status_next = (status_next | evt_vec) & `RCF_IMPL_MASK;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         status_reg <= '0;
      end else begin
         status_reg <= status_next;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mask_reg <= '0;
      end else if (mask_wr) begin
         mask_reg <= rif.wr_data[7:0] & `RCF_IMPL_MASK;
      end
   end

   // Outputs from flops: flag copy, core reset request, interrupt
   always_ff @(posedge clk) begin
      if (!rstn) begin
         reset_cause_register <= `RCF_FLAGS_RST;
         core_reset_pulse <= 1'b0;
         irq <= 1'b0;
      end else begin
         reset_cause_register <= flags_next;
         core_reset_pulse <= |evt_vec;
         irq <= |(status_next & mask_reg);
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence quiet_s;
      !flags_wr && evt_vec == 8'h00;
   endsequence

   sequence flags_write_s;
      flags_wr && evt_vec == 8'h00;
   endsequence

   sequence supply_evt_s;
      bor_evt || por_evt;
   endsequence

   ovf_sets_flag_a: assert property (ovf_evt && !por_evt && !bor_evt |=> flags_reg[7])
      else $error("stack overflow did not set its flag");

   unf_sets_flag_a: assert property (unf_evt && !por_evt && !bor_evt
      |=> flags_reg[6] ##1 (flags_reg[6] || $past(flags_wr || bor_evt || por_evt)))
      else $error("stack underflow flag not held");

   rsvd_reads_zero_a: assert property (flags_reg[5] == 1'b0 && reset_cause_register[5] == 1'b0)
      else $error("bit 5 not zero");

   wdt_clears_a: assert property (wdt_evt && !bor_evt && !por_evt |=> !flags_reg[4] && !reset_cause_register[4])
      else $error("watchdog flag not cleared");

   pin_clears_a: assert property ($fell(sync2_reg[0]) && !bor_evt && !por_evt |=> !flags_reg[3])
      else $error("pin reset flag not cleared");

   instr_clears_a: assert property (instr_evt && !bor_evt && !por_evt |=> flags_reg[2] == 1'b0)
      else $error("instruction reset flag not cleared");

   por_load_a: assert property (por_evt |=> flags_reg[7:1] == 7'h0e)
      else $error("power-on load wrong");

   bor_load_a: assert property (bor_evt && !por_evt |=> flags_reg[7:2] == 6'h07 && !flags_reg[0])
      else $error("brown-out load wrong");

   low_power_supply_monitor_path_a: assert property ($rose(sync2_reg[3]) && !prev_reg[2] && !sync2_reg[2] |-> bor_evt)
      else $error("low-power brown-out ignored");

   stack_gate_a: assert property (stack_overflow_pulse && !stack_en && !flags_wr && !por_evt && !bor_evt
                                  |=> flags_reg[7] == $past(flags_reg[7]) && !core_reset_pulse || $past(|evt_vec))
      else $error("stack event passed while disabled");

   sw_write_a: assert property (flags_write_s |=> flags_reg == ($past(rif.wr_data[7:0]) & 8'hdf))
      else $error("flag write not applied");

   flags_hold_a: assert property (quiet_s ##1 quiet_s |=> $stable(flags_reg))
      else $error("flags changed without cause");

   irq_follow_a: assert property ((status_reg & mask_reg) != 8'h00 |-> irq || $past(status_wr) || $past(mask_wr))
      else $error("interrupt missing for unmasked status");

   // Two flops sit between the pin and its event
   sequence pin_sync_fall_s;
      sync2_reg[0] && !sync1_reg[0] ##1 !sync2_reg[0];
   endsequence

   pin_two_flop_a: assert property (pin_sync_fall_s |-> pin_evt)
      else $error("pin fall not detected after two flops");

   bor_std_path_a: assert property ($rose(sync2_reg[2]) && !prev_reg[3] && !sync2_reg[3] |-> bor_evt)
      else $error("standard brown-out ignored");

   supply_load_a: assert property (supply_evt_s |=> flags_reg[7:6] == 2'h0 && flags_reg[4:2] == 3'h7)
      else $error("supply load of event flags wrong");

   // Active-low flags return to 1 only by firmware or the supply load
   wdt_only_set_a: assert property ($rose(flags_reg[4]) |-> $past(flags_wr || bor_evt || por_evt))
      else $error("watchdog flag set by hardware");

   pin_only_set_a: assert property ($rose(flags_reg[3]) |-> $past(flags_wr || bor_evt || por_evt))
      else $error("pin flag set by hardware");

   instr_only_set_a: assert property ($rose(flags_reg[2]) |-> $past(flags_wr || bor_evt || por_evt))
      else $error("instruction flag set by hardware");

   por_rearm_a: assert property ($rose(flags_reg[1]) |-> $past(flags_wr))
      else $error("power-on flag set by hardware");

   bor_rearm_a: assert property ($rose(flags_reg[0]) |-> $past(flags_wr))
      else $error("brown-out flag set by hardware");

   // Stack flags drop only by firmware or the supply load
   ovf_sticky_a: assert property ($fell(flags_reg[7]) |-> $past(flags_wr || bor_evt || por_evt))
      else $error("stack overflow flag dropped");

   unf_sticky_a: assert property ($fell(flags_reg[6]) |-> $past(flags_wr || bor_evt || por_evt))
      else $error("stack underflow flag dropped");

   // Each hardware set of a stack flag or clear of another flag has its own event behind it
   ovf_cause_a: assert property ($rose(flags_reg[7]) |-> $past(ovf_evt || flags_wr))
      else $error("stack overflow flag set without cause");

   unf_cause_a: assert property ($rose(flags_reg[6]) |-> $past(unf_evt || flags_wr))
      else $error("stack underflow flag set without cause");

   wdt_cause_a: assert property ($fell(flags_reg[4]) |-> $past(wdt_evt || flags_wr))
      else $error("watchdog flag cleared without cause");

   pin_cause_a: assert property ($fell(flags_reg[3]) |-> $past(pin_evt || flags_wr))
      else $error("pin flag cleared without cause");

   instr_cause_a: assert property ($fell(flags_reg[2]) |-> $past(instr_evt || flags_wr))
      else $error("instruction flag cleared without cause");

   por_cause_a: assert property ($fell(flags_reg[1]) |-> $past(por_evt || flags_wr))
      else $error("power-on flag cleared without cause");

   bor_cause_a: assert property ($fell(flags_reg[0]) |-> $past(bor_evt || flags_wr))
      else $error("brown-out flag cleared without cause");

   // Accepted stack events request a core reset
   stack_reset_a: assert property (ovf_evt || unf_evt |=> core_reset_pulse)
      else $error("no core reset after stack event");

   // Output copy mirrors the flag register
   copy_match_a: assert property (reset_cause_register == flags_reg)
      else $error("flag output differs from flag register");

   // Status is sticky and an event wins over a same-cycle clear
   status_set_a: assert property (evt_vec != 8'h00 |=> (status_reg & $past(evt_vec)) == $past(evt_vec))
      else $error("event not recorded in status");

   status_hold_a: assert property (!status_wr |=> (status_reg & $past(status_reg)) == $past(status_reg))
      else $error("status bit lost without clear");

   // Bit 5 stays clear in status and mask; upper read bits are zero
   rsvd_status_mask_a: assert property (status_reg[5] == 1'b0 && mask_reg[5] == 1'b0)
      else $error("bit 5 set in status or mask");

   rd_upper_zero_a: assert property (rdata[31:8] == 24'h000000)
      else $error("upper read data bits not zero");

   // Interrupt reflects the new status under the mask of the edge before
   irq_exact_a: assert property (1'b1 |=> irq == ((status_reg & $past(mask_reg)) != 8'h00))
      else $error("interrupt level wrong");
endmodule : rcf_reset_cause_flags

// File: verification/test_reset_cause_flags.sv
/*
 Self-checking bench of the reset-cause flag block: register access over
 AXI4-Lite, event pulses, supply and pin levels, interrupt.
 Assumes rcf_pkg and rcf_defs.svh of the design.
*/
`timescale 1ns/1ps
`include "rcf_defs.svh"
module test_reset_cause_flags
   import rcf_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   rcf_addr_t awaddr = 8'h00;
   rcf_addr_t araddr = 8'h00;
   rcf_data_t wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, core_reset_pulse, irq;
   rcf_resp_e bresp, rresp;
   rcf_data_t rdata;
   rcf_flags_t reset_cause_register;
   logic stack_overflow_pulse = 1'b0, stack_underflow_pulse = 1'b0;
   logic wdt_timeout_pulse = 1'b0, soft_reset_instr_pulse = 1'b0;
   logic external_reset_pin_n = 1'b1, por_req = 1'b0, bor_req = 1'b0;
   logic low_power_supply_monitor = 1'b0, stack_reset_enable = 1'b0;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;

   // 25 MHz clock
   always #20 clk = ~clk;

   // Verdict and end of run
   task give_verdict;
      if (num_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         give_verdict();
      end
   end

   // One comparison, four-state
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Write: address and data offered together, each released when taken
   task automatic wr(input rcf_addr_t a, input logic [7:0] d, input rcf_resp_e er);
      logic aw_p;
      logic w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge clk);
         if (aw_p && awready === 1'b1) begin
            awvalid <= 1'b0;
            aw_p = 1'b0;
         end
         if (w_p && wready === 1'b1) begin
            wvalid <= 1'b0;
            w_p = 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", er, bresp);
   endtask : wr

   // Read and compare data and response
   task automatic rd(input rcf_addr_t a, input logic [7:0] ed, input rcf_resp_e er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", {24'h000000, ed}, rdata);
      chk("rresp", er, rresp);
   endtask : rd

   // One-cycle pulse on {overflow, underflow, watchdog, instruction}, then sample
   task automatic fire(input logic [3:0] v, input logic [7:0] ef, input logic ep);
      @(posedge clk);
      {stack_overflow_pulse, stack_underflow_pulse, wdt_timeout_pulse, soft_reset_instr_pulse} <= v;
      @(posedge clk);
      {stack_overflow_pulse, stack_underflow_pulse, wdt_timeout_pulse, soft_reset_instr_pulse} <= 4'h0;
      @(posedge clk);
      chk("flags", ef, reset_cause_register);
      chk("core_reset_pulse", ep, core_reset_pulse);
   endtask : fire

   // Levels {pin_n, power-on, brown-out, low-power monitor}; waits out the synchroniser
   task automatic level(input logic [3:0] v, input logic [7:0] ef);
      @(posedge clk);
      {external_reset_pin_n, por_req, bor_req, low_power_supply_monitor} <= v;
      repeat (6) @(posedge clk);
      chk("flags", ef, reset_cause_register);
   endtask : level

   task s_reset;
      rd(`RCF_ADDR_FLAGS, 8'h1c, RCF_RESP_OKAY);
      rd(`RCF_ADDR_STATUS, 8'h00, RCF_RESP_OKAY);
      rd(8'h0c, 8'h00, RCF_RESP_SLVERR);
      wr(8'h0c, 8'hff, RCF_RESP_SLVERR);
      chk("irq", 1'b0, irq);
   endtask : s_reset

   task s_firmware;
      wr(`RCF_ADDR_FLAGS, 8'hff, RCF_RESP_OKAY);
      rd(`RCF_ADDR_FLAGS, 8'hdf, RCF_RESP_OKAY);
      wr(`RCF_ADDR_FLAGS, 8'h20, RCF_RESP_OKAY);
      rd(`RCF_ADDR_FLAGS, 8'h00, RCF_RESP_OKAY);
      chk("flags", 8'h00, reset_cause_register);
      wr(`RCF_ADDR_FLAGS, 8'h1f, RCF_RESP_OKAY);
      rd(`RCF_ADDR_FLAGS, 8'h1f, RCF_RESP_OKAY);
   endtask : s_firmware

   task s_stack;
      fire(4'hc, 8'h1f, 1'b0);
      @(posedge clk);
      stack_reset_enable <= 1'b1;
      repeat (4) @(posedge clk);
      fire(4'h8, 8'h9f, 1'b1);
      fire(4'h4, 8'hdf, 1'b1);
      rd(`RCF_ADDR_FLAGS, 8'hdf, RCF_RESP_OKAY);
      wr(`RCF_ADDR_FLAGS, 8'h1f, RCF_RESP_OKAY);
      rd(`RCF_ADDR_FLAGS, 8'h1f, RCF_RESP_OKAY);
   endtask : s_stack

   task s_clears;
      fire(4'h2, 8'h0f, 1'b1);
      fire(4'h1, 8'h0b, 1'b1);
      level(4'h0, 8'h03);
      level(4'h8, 8'h03);
      wr(`RCF_ADDR_FLAGS, 8'h1f, RCF_RESP_OKAY);
      rd(`RCF_ADDR_FLAGS, 8'h1f, RCF_RESP_OKAY);
   endtask : s_clears

   task s_supply;
      wr(`RCF_ADDR_FLAGS, 8'hc3, RCF_RESP_OKAY);
      level(4'h9, 8'h1e);
      level(4'h8, 8'h1e);
      wr(`RCF_ADDR_FLAGS, 8'hc3, RCF_RESP_OKAY);
      level(4'ha, 8'h1e);
      level(4'h8, 8'h1e);
      wr(`RCF_ADDR_FLAGS, 8'hc3, RCF_RESP_OKAY);
      level(4'hc, 8'h1d);
      level(4'h8, 8'h1d);
      wr(`RCF_ADDR_FLAGS, 8'h1f, RCF_RESP_OKAY);
      rd(`RCF_ADDR_FLAGS, 8'h1f, RCF_RESP_OKAY);
   endtask : s_supply

   task s_irq;
      wr(`RCF_ADDR_STATUS, 8'hff, RCF_RESP_OKAY);
      rd(`RCF_ADDR_STATUS, 8'h00, RCF_RESP_OKAY);
      wr(`RCF_ADDR_MASK, 8'h10, RCF_RESP_OKAY);
      rd(`RCF_ADDR_MASK, 8'h10, RCF_RESP_OKAY);
      fire(4'h1, 8'h1b, 1'b1);
      chk("irq", 1'b0, irq);
      fire(4'h2, 8'h0b, 1'b1);
      chk("irq", 1'b1, irq);
      wr(`RCF_ADDR_STATUS, 8'h10, RCF_RESP_OKAY);
      chk("irq", 1'b0, irq);
      rd(`RCF_ADDR_STATUS, 8'h04, RCF_RESP_OKAY);
   endtask : s_irq

   // Mid-run reset: power-on view of the flags, interrupt and mask cleared
   task s_rerun;
      fire(4'h2, 8'h0b, 1'b1);
      chk("irq", 1'b1, irq);
      wr(`RCF_ADDR_FLAGS, 8'hc0, RCF_RESP_OKAY);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk("flags", 8'h1c, reset_cause_register);
      chk("irq", 1'b0, irq);
      rd(`RCF_ADDR_MASK, 8'h00, RCF_RESP_OKAY);
      rd(`RCF_ADDR_STATUS, 8'h00, RCF_RESP_OKAY);
      rd(`RCF_ADDR_FLAGS, 8'h1c, RCF_RESP_OKAY);
   endtask : s_rerun

   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      s_reset();
      s_firmware();
      s_stack();
      s_clears();
      s_supply();
      s_irq();
      s_rerun();
      give_verdict();
   end

   rcf_reset_cause_flags u_dut (
      .clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .stack_overflow_pulse, .stack_underflow_pulse, .wdt_timeout_pulse, .soft_reset_instr_pulse,
      .external_reset_pin_n, .por_req, .bor_req, .low_power_supply_monitor, .stack_reset_enable,
      .reset_cause_register, .core_reset_pulse, .irq
   );
endmodule : test_reset_cause_flags
